// ---- core/srpc_defines.vh ----
// constants for the supply regulator and power control block
`ifndef SRPC_DEFINES_VH
`define SRPC_DEFINES_VH
`define SRPC_ADDR_CHIP_STATE 5'h00
`define SRPC_ADDR_REG_CTRL 5'h0B
`define SRPC_CHIP_STATE_RST 8'h00
`define SRPC_REG_CTRL_RST 8'h87
`define SRPC_BIT_SUPPLY_3V 0
`define SRPC_BIT_RX_ONLY 1
`define SRPC_BIT_RF_FULL 5
`define SRPC_BIT_STANDBY 7
`define SRPC_BIT_AUTO 7
// rail voltages in units of 100 mV, margins in units of 10 mV
`define SRPC_RAIL_5V_BASE 6'h2B
`define SRPC_RAIL_3V_BASE 6'h1B
`define SRPC_RAIL_PA_MAX 6'h32
`define SRPC_RAIL_LOGIC_MAX 6'h22
`define SRPC_MARGIN_250 6'h19
`define SRPC_MARGIN_350 6'h23
`define SRPC_MARGIN_400 6'h28
`endif

// ---- core/srpc_supply_power_ctrl.v ----
// supply configuration, regulator mode decode and power state logic
`timescale 1ns/100ps
`include "srpc_defines.vh"
module srpc_supply_power_ctrl (
    input wire CORE_CLK_IN,
    input wire RST_IN,
    input wire PRIMARY_WAKE_IN,
    input wire SECONDARY_WAKE_PIN_IN,
    input wire WR_EN_IN,
    input wire [4:0] ADDR_IN,
    input wire [7:0] WDATA_IN,
    output reg [7:0] RDATA_OUT,
    output reg SUPPLY_3V_OUT,
    output reg AUTO_MODE_OUT,
    output reg [5:0] AUTO_MARGIN_OUT,
    output reg [5:0] AMPLIFIER_SUPPLY_RAIL_OUT,
    output reg [5:0] ANALOG_RAIL_OUT,
    output reg [5:0] DIGITAL_RAIL_OUT,
    output reg [5:0] RAIL_CEIL_PA_OUT,
    output reg [5:0] RAIL_CEIL_LOGIC_OUT,
    output reg AUTO_ADJUST_START_OUT,
    output reg REGULATORS_EN_OUT,
    output reg OSC_EN_OUT,
    output reg HOST_CLOCK_OUTPUT_EN_OUT,
    output reg AUX_CLOCK_EN_OUT,
    output reg STANDBY_OUT,
    output reg TX_EN_OUT,
    output reg RX_EN_OUT
);
// ****************************************
// pin synchronisers
// ****************************************
reg [2:0] wake_sync_reg;
reg [2:0] wake2_sync_reg;
reg wake_reg;
reg wake2_reg;
always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
        wake_sync_reg <= 3'h0;
        wake2_sync_reg <= 3'h0;
        wake_reg <= 1'b0;
        wake2_reg <= 1'b0;
    end else begin
        wake_sync_reg <= {wake_sync_reg[1:0], PRIMARY_WAKE_IN};
        wake2_sync_reg <= {wake2_sync_reg[1:0], SECONDARY_WAKE_PIN_IN};
        // change counts only when stages two and three agree
        if (wake_sync_reg[2] == wake_sync_reg[1])
            wake_reg <= wake_sync_reg[2];
        if (wake2_sync_reg[2] == wake2_sync_reg[1])
            wake2_reg <= wake2_sync_reg[2];
    end
end
// ****************************************
// registers
// ****************************************
reg [7:0] chip_state_control_reg;
reg [7:0] regulator_io_control_reg;
reg wake_d_reg;
reg auto_d_reg;
always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
        chip_state_control_reg <= `SRPC_CHIP_STATE_RST;
        regulator_io_control_reg <= `SRPC_REG_CTRL_RST;
        wake_d_reg <= 1'b0;
        auto_d_reg <= 1'b1;
    end else begin
        if (WR_EN_IN && ADDR_IN == `SRPC_ADDR_CHIP_STATE)
            chip_state_control_reg <= WDATA_IN;
        if (WR_EN_IN && ADDR_IN == `SRPC_ADDR_REG_CTRL)
            regulator_io_control_reg <= WDATA_IN;
        wake_d_reg <= wake_reg;
        auto_d_reg <= regulator_io_control_reg[`SRPC_BIT_AUTO];
    end
end
always @* begin
    case (ADDR_IN)
        `SRPC_ADDR_CHIP_STATE: RDATA_OUT = chip_state_control_reg;
        `SRPC_ADDR_REG_CTRL: RDATA_OUT = regulator_io_control_reg;
        default: RDATA_OUT = 8'h00;
    endcase
end
// ****************************************
// regulator decode
// ****************************************
// rail source picked once, then shared by all three rail outputs
localparam [1:0] RAIL_MODE_AUTO = 2'h0;
localparam [1:0] RAIL_MODE_MAN_5V = 2'h1;
localparam [1:0] RAIL_MODE_MAN_3V = 2'h2;
wire [2:0] code = regulator_io_control_reg[2:0];
wire is_3v = chip_state_control_reg[`SRPC_BIT_SUPPLY_3V];
wire is_auto = regulator_io_control_reg[`SRPC_BIT_AUTO];
wire [5:0] code6 = {3'h0, code};
reg [1:0] rail_mode;
reg supply_3v_next;
reg auto_mode_next;
reg [5:0] auto_margin_next;
reg [5:0] ceil_pa_next;
reg [5:0] ceil_logic_next;
reg [5:0] pa_rail_next;
reg [5:0] analog_rail_next;
reg [5:0] digital_rail_next;
always @* begin
    if (is_auto) begin
        rail_mode = RAIL_MODE_AUTO;
    end else if (is_3v) begin
        rail_mode = RAIL_MODE_MAN_3V;
    end else begin
        rail_mode = RAIL_MODE_MAN_5V;
    end
end
always @* begin
    supply_3v_next = is_3v;
    auto_mode_next = is_auto;
end
always @* begin
    // code 01 is undefined; treated as the widest margin
    case (code[1:0])
        2'b11: begin
            auto_margin_next = `SRPC_MARGIN_250;
        end
        2'b10: begin
            auto_margin_next = `SRPC_MARGIN_350;
        end
        default: begin
            auto_margin_next = `SRPC_MARGIN_400;
        end
    endcase
end
always @* begin
    // a 3-V supply cannot lift the amplifier rail above the logic ceiling
    if (is_3v) begin
        ceil_pa_next = `SRPC_RAIL_LOGIC_MAX;
    end else begin
        ceil_pa_next = `SRPC_RAIL_PA_MAX;
    end
    ceil_logic_next = `SRPC_RAIL_LOGIC_MAX;
end
always @* begin
    case (rail_mode)
        RAIL_MODE_AUTO: begin
            // analog tracker not modelled; report the ceilings
            pa_rail_next = ceil_pa_next;
            analog_rail_next = ceil_logic_next;
            digital_rail_next = ceil_logic_next;
        end
        RAIL_MODE_MAN_5V: begin
            pa_rail_next = `SRPC_RAIL_5V_BASE + code6;
            analog_rail_next = `SRPC_RAIL_LOGIC_MAX;
            digital_rail_next = `SRPC_RAIL_LOGIC_MAX;
        end
        RAIL_MODE_MAN_3V: begin
            pa_rail_next = `SRPC_RAIL_3V_BASE + code6;
            analog_rail_next = `SRPC_RAIL_3V_BASE + code6;
            digital_rail_next = `SRPC_RAIL_3V_BASE + code6;
        end
        default: begin
            pa_rail_next = ceil_pa_next;
            analog_rail_next = ceil_logic_next;
            digital_rail_next = ceil_logic_next;
        end
    endcase
end
// ****************************************
// output registers
// ****************************************
// decode reaches the pins one cycle after a register write
always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
        SUPPLY_3V_OUT <= 1'b0;
        AUTO_MODE_OUT <= 1'b1;
        AUTO_MARGIN_OUT <= `SRPC_MARGIN_250;
        RAIL_CEIL_PA_OUT <= `SRPC_RAIL_PA_MAX;
        RAIL_CEIL_LOGIC_OUT <= `SRPC_RAIL_LOGIC_MAX;
        AMPLIFIER_SUPPLY_RAIL_OUT <= `SRPC_RAIL_PA_MAX;
        ANALOG_RAIL_OUT <= `SRPC_RAIL_LOGIC_MAX;
        DIGITAL_RAIL_OUT <= `SRPC_RAIL_LOGIC_MAX;
    end else begin
        SUPPLY_3V_OUT <= supply_3v_next;
        AUTO_MODE_OUT <= auto_mode_next;
        AUTO_MARGIN_OUT <= auto_margin_next;
        RAIL_CEIL_PA_OUT <= ceil_pa_next;
        RAIL_CEIL_LOGIC_OUT <= ceil_logic_next;
        AMPLIFIER_SUPPLY_RAIL_OUT <= pa_rail_next;
        ANALOG_RAIL_OUT <= analog_rail_next;
        DIGITAL_RAIL_OUT <= digital_rail_next;
    end
end
// ****************************************
// regulator adjustment start
// ****************************************
always @* begin
    // one-cycle pulse; a rise while already high needs 1-0-1
    AUTO_ADJUST_START_OUT = 1'b0;
    if (is_auto) begin
        if (wake_reg && !wake_d_reg) begin
            AUTO_ADJUST_START_OUT = 1'b1;
        end
        if (!auto_d_reg) begin
            AUTO_ADJUST_START_OUT = 1'b1;
        end
    end
end
// ****************************************
// power state
// ****************************************
always @* begin
    REGULATORS_EN_OUT = wake_reg;
    OSC_EN_OUT = wake_reg;
    HOST_CLOCK_OUTPUT_EN_OUT = wake_reg;
end
always @* begin
    // secondary pin alone keeps the low-rate clock alive in sleep
    AUX_CLOCK_EN_OUT = !wake_reg && wake2_reg;
end
always @* begin
    STANDBY_OUT = 1'b0;
    TX_EN_OUT = 1'b0;
    RX_EN_OUT = 1'b0;
    if (wake_reg) begin
        // standby overrides both radio enables
        if (chip_state_control_reg[`SRPC_BIT_STANDBY]) begin
            STANDBY_OUT = 1'b1;
        end else begin
            TX_EN_OUT = chip_state_control_reg[`SRPC_BIT_RF_FULL];
            RX_EN_OUT = chip_state_control_reg[`SRPC_BIT_RF_FULL] ||
                chip_state_control_reg[`SRPC_BIT_RX_ONLY];
        end
    end
end
endmodule // srpc_supply_power_ctrl

// ---- testbench/srpc_properties.sv ----
// port assertions for the supply and power control block
`timescale 1ns/100ps
module srpc_props (
    input wire CORE_CLK_IN, RST_IN, WR_EN_IN, SUPPLY_3V_OUT,
    input wire AUTO_MODE_OUT, AUTO_ADJUST_START_OUT,
    input wire STANDBY_OUT, TX_EN_OUT, RX_EN_OUT,
    input wire [4:0] ADDR_IN,
    input wire [7:0] WDATA_IN,
    input wire [5:0] AUTO_MARGIN_OUT, AMPLIFIER_SUPPLY_RAIL_OUT, ANALOG_RAIL_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    wire w0 = WR_EN_IN && ADDR_IN == 5'h00;
    wire wb = WR_EN_IN && ADDR_IN == 5'h0B;
    property p_sup;
        w0 |=> ##1 SUPPLY_3V_OUT == $past(WDATA_IN[0], 2);
    endproperty
    a_sup: assert property (p_sup) else $error("supply bit");
    property p_mod;
        wb |=> ##1 AUTO_MODE_OUT == $past(WDATA_IN[7], 2);
    endproperty
    a_mod: assert property (p_mod) else $error("mode bit");
    property p_mrg;
        wb && WDATA_IN[1:0] == 2'h2 |=> ##1 AUTO_MARGIN_OUT == 6'h23;
    endproperty
    a_mrg: assert property (p_mrg) else $error("margin");
    property p_m5; wb && !WDATA_IN[7] && !SUPPLY_3V_OUT |=>
        ##1 AMPLIFIER_SUPPLY_RAIL_OUT == 6'h2B + $past(WDATA_IN[2:0], 2);
    endproperty
    a_m5: assert property (p_m5) else $error("5v rail");
    property p_m3; !AUTO_MODE_OUT && SUPPLY_3V_OUT |->
        AMPLIFIER_SUPPLY_RAIL_OUT == ANALOG_RAIL_OUT; endproperty
    a_m3: assert property (p_m3) else $error("3v rails");
    property p_clp; AUTO_MODE_OUT |-> AMPLIFIER_SUPPLY_RAIL_OUT <= 6'h32
        && ANALOG_RAIL_OUT <= 6'h22; endproperty
    a_clp: assert property (p_clp) else $error("ceiling");
    property p_st; $rose(AUTO_MODE_OUT) |-> $past(AUTO_ADJUST_START_OUT);
    endproperty
    a_st: assert property (p_st) else $error("no start");
    property p_sb; STANDBY_OUT |-> !TX_EN_OUT && !RX_EN_OUT; endproperty
    a_sb: assert property (p_sb) else $error("standby");
endmodule // srpc_props
bind srpc_supply_power_ctrl srpc_props i_props (.*);

// ---- testbench/srpc_host.sv ----
// host model driving wake pins and register writes
`timescale 1ns/100ps
module srpc_host (
    input wire CORE_CLK_IN,
    output reg WR_EN_IN, PRIMARY_WAKE_IN, SECONDARY_WAKE_PIN_IN,
    output reg [4:0] ADDR_IN,
    output reg [7:0] WDATA_IN
);
    initial {WR_EN_IN, PRIMARY_WAKE_IN, SECONDARY_WAKE_PIN_IN} = 3'h0;
    initial {ADDR_IN, WDATA_IN} = 13'h0000;
    task wr(input [4:0] a, input [7:0] d); begin
        @(negedge CORE_CLK_IN) {WR_EN_IN, ADDR_IN, WDATA_IN} = {1'b1, a, d};
        // data scrambled once released
        @(negedge CORE_CLK_IN) {WR_EN_IN, WDATA_IN} = {1'b0, ~d};
    end endtask
    task sel(input [4:0] a); @(negedge CORE_CLK_IN) ADDR_IN = a; endtask
    task pins(input w, w2);
        @(negedge CORE_CLK_IN) {PRIMARY_WAKE_IN, SECONDARY_WAKE_PIN_IN} = {w, w2};
    endtask
    task rerun; begin wr(5'h0B, 8'h07); wr(5'h0B, 8'h87); end endtask
    task cfg(input int mv); wr(5'h00, {7'h00, mv < 4300}); endtask
endmodule // srpc_host

// ---- testbench/srpc_supply_power_ctrl_bench.sv ----
// random bench for supply and power control
`timescale 1ns/100ps
module srpc_supply_power_ctrl_bench;
    reg CORE_CLK_IN = 1'b0, RST_IN = 1'b1;
    wire WR_EN_IN, PRIMARY_WAKE_IN, SECONDARY_WAKE_PIN_IN, SUPPLY_3V_OUT;
    wire AUTO_MODE_OUT, AUTO_ADJUST_START_OUT, REGULATORS_EN_OUT, OSC_EN_OUT;
    wire HOST_CLOCK_OUTPUT_EN_OUT, AUX_CLOCK_EN_OUT, STANDBY_OUT, TX_EN_OUT;
    wire RX_EN_OUT;
    wire [4:0] ADDR_IN;
    wire [7:0] WDATA_IN, RDATA_OUT;
    wire [5:0] AUTO_MARGIN_OUT, AMPLIFIER_SUPPLY_RAIL_OUT, ANALOG_RAIL_OUT;
    wire [5:0] DIGITAL_RAIL_OUT, RAIL_CEIL_PA_OUT, RAIL_CEIL_LOGIC_OUT;
    integer bad_count = 0, cmp_count = 0, i, n;
    reg [7:0] cs, rc;
    srpc_host i_host (.*);
    srpc_supply_power_ctrl i_dut (.*);
    initial forever #5 CORE_CLK_IN = ~CORE_CLK_IN;
    task chk(input [23:0] g, e); begin
        cmp_count++;
        if (g !== e) begin bad_count++; $display("[ERR] %0t %h/%h", $time, g, e); end
    end endtask
    function [23:0] ev(input [7:0] c, r); // margin and three rails
        reg [5:0] m, a;
        m = r[1:0] == 2'h3 ? 6'h19 : r[1:0] == 2'h2 ? 6'h23 : 6'h28;
        a = (!r[7] && c[0]) ? 6'h1B + r[2:0] : 6'h22;
        ev = {m, r[7] ? (c[0] ? a : 6'h32) : (c[0] ? a : 6'h2B + r[2:0]), a, a};
    endfunction
    task end_of_test; begin
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    end endtask
    initial begin
        i = $urandom(63986);
        repeat (4) @(posedge CORE_CLK_IN);
        @(negedge CORE_CLK_IN) RST_IN = 1'b0;
        i_host.sel(5'h00); #1 chk(RDATA_OUT, 8'h00);
        chk({AUTO_MARGIN_OUT, AMPLIFIER_SUPPLY_RAIL_OUT, ANALOG_RAIL_OUT,
            DIGITAL_RAIL_OUT}, ev(8'h00, 8'h87));
        i_host.wr(5'h05, 8'hFF); chk(RDATA_OUT, 8'h00);
        $display("reset test done");
        for (i = 0; i < 48; i++) begin
            cs = $urandom; rc = $urandom;
            if (i < 32) begin cs[0] = i[4]; rc[7] = i[3]; rc[2:0] = i[2:0]; end
            i_host.wr(5'h00, cs); i_host.wr(5'h0B, rc);
            chk(RDATA_OUT, rc);
            @(negedge CORE_CLK_IN);
            chk({RAIL_CEIL_PA_OUT, RAIL_CEIL_LOGIC_OUT},
                {cs[0] ? 6'h22 : 6'h32, 6'h22});
            chk(SUPPLY_3V_OUT, cs[0]);
            chk({AUTO_MARGIN_OUT, AMPLIFIER_SUPPLY_RAIL_OUT, ANALOG_RAIL_OUT,
                DIGITAL_RAIL_OUT}, ev(cs, rc));
        end
        $display("decode test done");
        i_host.cfg(5000); i_host.rerun; i_host.pins(1'b0, 1'b1);
        repeat (6) @(negedge CORE_CLK_IN);
        chk(AUX_CLOCK_EN_OUT, 1'b1);
        i_host.pins(1'b1, 1'b0); n = 0;
        // sync needs four edges, so eight is ample
        repeat (8) @(negedge CORE_CLK_IN) n += AUTO_ADJUST_START_OUT;
        chk(n, 1);
        chk({REGULATORS_EN_OUT, OSC_EN_OUT, HOST_CLOCK_OUTPUT_EN_OUT}, 3'h7);
        chk(AUX_CLOCK_EN_OUT, 1'b0);
        for (i = 0; i < 12; i++) begin
            cs = i < 4 ? 8'h81 >> i * 2 ^ 8'h20 * i[0] : $urandom;
            i_host.wr(5'h00, cs);
            chk({STANDBY_OUT, TX_EN_OUT, RX_EN_OUT}, cs[7] ? 3'h4 :
                {1'b0, cs[5], cs[5] | cs[1]});
        end
        $display("power test done");
        end_of_test;
    end
endmodule // srpc_supply_power_ctrl_bench
